// File: ebls_consts.svh
`ifndef EBLS_CONSTS_SVH
`define EBLS_CONSTS_SVH
`define EBLS_LANES 4
`define EBLS_OWNER_STATIC 1'b0
`define EBLS_OWNER_SDRAM 1'b1
`define EBLS_STROBE_IDLE 4'hf
`define EBLS_ADDR_LO_RESET 2'h0
`define EBLS_PIN_IDLE 1'b1
`define EBLS_ADDR_PIN_RESET 1'b0
`endif

// File: ebls_lane_decode.sv
`include "ebls_consts.svh"
module ebls_lane_decode
  import ebls_pkg::*;
#(
  parameter int LANES = `EBLS_LANES
) (
  input wire logic [LANES-1:0] laneEnable,
  input wire logic accessActive,
  input wire logic writeAccess,
  input wire ebls_mode_e strobeMode,
  output logic [LANES-1:0] writeStrobeN,
  output logic [LANES-1:0] byteSelectN
);
  // one generate per lane so each lane pin sees only its own enable
  for (genvar lane = 0; lane < LANES; lane++) begin : gLane
    always_comb begin
      writeStrobeN[lane] = 1'b1;
      byteSelectN[lane] = 1'b1;
      if (accessActive) begin
        if (strobeMode == EBLS_MODE_WRITE_STROBE) begin
          writeStrobeN[lane] = ~(writeAccess & laneEnable[lane]);
        end else begin
          byteSelectN[lane] = ~laneEnable[lane];
        end
      end
    end
  end
endmodule

// File: ebls_pkg.sv
package ebls_pkg;
  typedef enum logic [1:0] {
    EBLS_WIDTH_8,
    EBLS_WIDTH_16,
    EBLS_WIDTH_32
  } ebls_width_e;
  typedef enum logic {
    EBLS_MODE_WRITE_STROBE,
    EBLS_MODE_BYTE_SELECT
  } ebls_mode_e;
  typedef enum logic {
    EBLS_OWN_STATIC,
    EBLS_OWN_SDRAM
  } ebls_owner_e;
endpackage

// File: ebls_sram_model.sv
module ebls_sram_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] wsN,
  output logic [3:0] lanesSeen_q
);
  // no data bus here, so the parts only remember which lanes were ever written
  always_ff @(posedge clk, posedge sys_rst) begin
    if (sys_rst) begin
      lanesSeen_q <= 4'h0;
    end else begin
      lanesSeen_q <= lanesSeen_q | ~wsN;
    end
  end
endmodule

// File: ebls_strobe_mux.sv
`include "ebls_consts.svh"
// Summary of operation
// - two 8-bit parts: lane1 strobe for upper byte, lane0 strobe for lower byte only
// - four 8-bit parts: write strobe x asserted only when byte lane x is written
// - byte-select mode: select 0 and 1 qualify low and high bytes of lower half
// - byte-select mode: select 2 and 3 qualify low and high bytes of upper half
// - owner bit hands shared chip select one to static (0) or SDRAM (1) controller
module ebls_strobe_mux
  import ebls_pkg::*;
#(
  parameter int LANES = `EBLS_LANES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ebls_width_e busWidth,
  input wire ebls_mode_e strobeMode,
  input wire logic csOneOwnerSelect,
  input wire logic staticAccess,
  input wire logic staticWrite,
  input wire logic [LANES-1:0] staticByteEnable,
  input wire logic [1:0] staticAddrLow,
  input wire logic staticCsOneN,
  input wire logic sdramAccess,
  input wire logic [LANES-1:0] sdramDqmN,
  input wire logic sdramCsN,
  output logic write_strobe_lane0_n,
  output logic write_strobe_lane1_n,
  output logic write_strobe_lane2_n,
  output logic write_strobe_lane3_n,
  output logic byte_select_lane0_n,
  output logic byte_select_lane1_n,
  output logic byte_select_lane2_n,
  output logic byte_select_lane3_n,
  output logic shared_chip_select_one_n,
  output logic addrLowOut0,
  output logic addrLowOut1
);
  // the pin list below is fixed at four lanes, so other counts cannot be served
  initial begin
    if (LANES != 4) begin
      $error("ebls_strobe_mux serves exactly four byte lanes");
    end
  end

  logic [LANES-1:0] laneEnable;
  logic [LANES-1:0] wrN;
  logic [LANES-1:0] bsN;
  logic staticOwnsAccess;
  ebls_owner_e csOneOwner;
  logic [LANES-1:0] wr_d;
  logic [LANES-1:0] bs_d;
  logic csOne_d;
  logic [1:0] addr_d;

  // narrow buses use only the low lanes; upper lanes never assert there
  always_comb begin
    laneEnable = '0;
    unique case (busWidth)
      EBLS_WIDTH_8: begin
        laneEnable[0] = staticByteEnable[0];
      end
      EBLS_WIDTH_16: begin
        laneEnable[1:0] = staticByteEnable[1:0];
      end
      EBLS_WIDTH_32: begin
        laneEnable = staticByteEnable;
      end
      default: begin
        laneEnable = '0;
      end
    endcase
  end

  // static controller owns the pins unless the SDRAM controller has the access
  assign staticOwnsAccess = staticAccess & ~sdramAccess;

  // decode serves static accesses only; SDRAM masks bypass it
  ebls_lane_decode #(
    .LANES(LANES)
  ) uDecode (
    .laneEnable(laneEnable),
    .accessActive(staticOwnsAccess),
    .writeAccess(staticWrite),
    .strobeMode(strobeMode),
    .writeStrobeN(wrN),
    .byteSelectN(bsN)
  );

  // write strobes stay idle whenever the SDRAM controller holds the bus
  always_comb begin
    wr_d = `EBLS_STROBE_IDLE;
    if (staticOwnsAccess) begin
      wr_d = wrN;
    end
  end

  // SDRAM byte masks ride on the byte-select pins during its access
  always_comb begin
    bs_d = `EBLS_STROBE_IDLE;
    if (sdramAccess) begin
      bs_d = sdramDqmN;
    end else if (staticOwnsAccess) begin
      bs_d = bsN;
    end
  end

  // an 8-bit device needs both low address bits on the shared pins
  always_comb begin
    addr_d = `EBLS_ADDR_LO_RESET;
    if (staticOwnsAccess && busWidth == EBLS_WIDTH_8) begin
      addr_d = staticAddrLow;
    end
  end

  assign csOneOwner = (csOneOwnerSelect == `EBLS_OWNER_SDRAM) ? EBLS_OWN_SDRAM : EBLS_OWN_STATIC;

  // select one follows its owner even between accesses
  always_comb begin
    unique case (csOneOwner)
      EBLS_OWN_SDRAM: begin
        csOne_d = sdramCsN;
      end
      EBLS_OWN_STATIC: begin
        csOne_d = staticCsOneN;
      end
    endcase
  end

  // every pin leaves a flop so owner switches cannot glitch the parts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_strobe_lane0_n <= `EBLS_PIN_IDLE;
    end else begin
      write_strobe_lane0_n <= wr_d[0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_strobe_lane1_n <= `EBLS_PIN_IDLE;
    end else begin
      write_strobe_lane1_n <= wr_d[1];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_strobe_lane2_n <= `EBLS_PIN_IDLE;
    end else begin
      write_strobe_lane2_n <= wr_d[2];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_strobe_lane3_n <= `EBLS_PIN_IDLE;
    end else begin
      write_strobe_lane3_n <= wr_d[3];
    end
  end

  // byte selects also carry the SDRAM masks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_select_lane0_n <= `EBLS_PIN_IDLE;
    end else begin
      byte_select_lane0_n <= bs_d[0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_select_lane1_n <= `EBLS_PIN_IDLE;
    end else begin
      byte_select_lane1_n <= bs_d[1];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_select_lane2_n <= `EBLS_PIN_IDLE;
    end else begin
      byte_select_lane2_n <= bs_d[2];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_select_lane3_n <= `EBLS_PIN_IDLE;
    end else begin
      byte_select_lane3_n <= bs_d[3];
    end
  end

  // shared chip select parks high during reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_chip_select_one_n <= `EBLS_PIN_IDLE;
    end else begin
      shared_chip_select_one_n <= csOne_d;
    end
  end

  // low address pins rest at zero outside 8-bit static accesses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addrLowOut0 <= `EBLS_ADDR_PIN_RESET;
    end else begin
      addrLowOut0 <= addr_d[0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addrLowOut1 <= `EBLS_ADDR_PIN_RESET;
    end else begin
      addrLowOut1 <= addr_d[1];
    end
  end
endmodule

// File: ebls_strobe_mux_properties.sv
module ebls_strobe_mux_chk
  import ebls_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic csOneOwnerSelect,
  input wire logic staticAccess,
  input wire logic staticWrite,
  input wire logic staticCsOneN,
  input wire logic sdramAccess,
  input wire logic sdramCsN,
  input wire ebls_width_e busWidth,
  input wire ebls_mode_e strobeMode,
  input wire logic [3:0] staticByteEnable,
  input wire logic [3:0] sdramDqmN,
  input wire logic write_strobe_lane0_n,
  input wire logic write_strobe_lane1_n,
  input wire logic write_strobe_lane2_n,
  input wire logic write_strobe_lane3_n,
  input wire logic byte_select_lane0_n,
  input wire logic byte_select_lane1_n,
  input wire logic byte_select_lane2_n,
  input wire logic byte_select_lane3_n,
  input wire logic shared_chip_select_one_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic [3:0] ws = {write_strobe_lane3_n, write_strobe_lane2_n, write_strobe_lane1_n, write_strobe_lane0_n};
  wire logic [3:0] bs = {byte_select_lane3_n, byte_select_lane2_n, byte_select_lane1_n, byte_select_lane0_n};
  wire logic st = staticAccess && !sdramAccess;
  wire logic wm = st && staticWrite && strobeMode == EBLS_MODE_WRITE_STROBE;
  wire logic bm = st && strobeMode == EBLS_MODE_BYTE_SELECT && busWidth == EBLS_WIDTH_32;
  property p_w16; wm && busWidth == EBLS_WIDTH_16 |=> ws == {2'h3, ~$past(staticByteEnable[1:0])}; endproperty
  a_w16: assert property (p_w16) else $error("two-part strobes wrong");
  property p_w32; wm && busWidth == EBLS_WIDTH_32 |=> ws == ~$past(staticByteEnable); endproperty
  a_w32: assert property (p_w32) else $error("four-part strobes wrong");
  property p_blo; bm |=> bs[1:0] == ~$past(staticByteEnable[1:0]) && ws == 4'hf; endproperty
  a_blo: assert property (p_blo) else $error("lower half selects wrong");
  property p_bhi; bm |=> bs[3:2] == ~$past(staticByteEnable[3:2]); endproperty
  a_bhi: assert property (p_bhi) else $error("upper half selects wrong");
  // the first sample after release is skipped: its capture edge is not pinned down
  property p_cs; !$past(sys_rst) |=> shared_chip_select_one_n == ($past(csOneOwnerSelect) ? $past(sdramCsN)
    : $past(staticCsOneN)); endproperty
  a_cs: assert property (p_cs) else $error("shared select from wrong owner");
  property p_sd; sdramAccess |=> bs == $past(sdramDqmN) && ws == 4'hf; endproperty
  a_sd: assert property (p_sd) else $error("sdram pins wrong");
endmodule

bind ebls_strobe_mux ebls_strobe_mux_chk ebls_strobe_mux_chk_i (.*);

// File: tb_top.sv
module tb_top
  import ebls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, sys_rst = 1'b1, csOneOwnerSelect, staticAccess, staticWrite, staticCsOneN, sdramAccess, sdramCsN;
  logic [3:0] staticByteEnable, sdramDqmN, lanesSeen;
  logic [1:0] staticAddrLow;
  ebls_width_e busWidth;
  ebls_mode_e strobeMode;
  wire logic [10:0] got;
  int err_count = 0, compares = 0;
  initial forever #25 clk = ~clk;
  ebls_strobe_mux ebls_strobe_mux_i (.*, .write_strobe_lane0_n(got[5]), .write_strobe_lane1_n(got[6]),
    .write_strobe_lane2_n(got[7]), .write_strobe_lane3_n(got[8]), .byte_select_lane0_n(got[1]),
    .byte_select_lane1_n(got[2]), .byte_select_lane2_n(got[3]), .byte_select_lane3_n(got[4]),
    .shared_chip_select_one_n(got[0]), .addrLowOut0(got[9]), .addrLowOut1(got[10]));
  ebls_sram_model ebls_sram_model_i (.clk(clk), .sys_rst(sys_rst), .wsN(got[8:5]), .lanesSeen_q(lanesSeen));
  function automatic logic [10:0] ev();
    logic [3:0] e;
    e = ~(staticByteEnable & (busWidth == EBLS_WIDTH_32 ? 4'hf : busWidth == EBLS_WIDTH_16 ? 4'h3
      : busWidth == EBLS_WIDTH_8 ? 4'h1 : 4'h0));
    ev[10:9] = (!sdramAccess && staticAccess && busWidth == EBLS_WIDTH_8) ? staticAddrLow : 2'h0;
    ev[0] = csOneOwnerSelect ? sdramCsN : staticCsOneN;
    ev[8:1] = sdramAccess ? {4'hf, sdramDqmN} : !staticAccess ? 8'hff
      : strobeMode == EBLS_MODE_BYTE_SELECT ? {4'hf, e} : staticWrite ? {e, 4'hf} : 8'hff;
  endfunction
  task automatic chk(input logic [10:0] g, input logic [10:0] x);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask
  // inputs stay put for two edges so the registered pins are judged on one settled sample
  task automatic check_next();
    logic [10:0] e;
    #1 e = ev();
    @(posedge clk);
    #1 chk(got, e);
  endtask
  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {csOneOwnerSelect, staticAccess, staticWrite, staticCsOneN, sdramAccess, sdramCsN} = 6'h0;
    {staticByteEnable, sdramDqmN, staticAddrLow} = 10'h0;
    busWidth = EBLS_WIDTH_8;
    strobeMode = EBLS_MODE_WRITE_STROBE;
    void'($urandom(32'he85d1642));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    {staticAccess, staticWrite, staticByteEnable} <= 6'h34;
    busWidth <= EBLS_WIDTH_32;
    check_next();
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      {csOneOwnerSelect, staticAccess, staticWrite, staticCsOneN, sdramCsN, staticByteEnable, sdramDqmN,
        staticAddrLow} <= 15'($urandom);
      sdramAccess <= $urandom_range(3) == 0;
      busWidth <= ebls_width_e'($urandom_range(3));
      strobeMode <= ebls_mode_e'($urandom_range(1));
      check_next();
    end
    chk({7'h0, lanesSeen}, 11'h00f);
    print_verdict();
  end
endmodule
